// File: logic/adcp_pkg.sv
`default_nettype none
package adcp_pkg;
   // ====================================
   // control byte layout
   localparam int CTRL_MODE_HI = 7;
   localparam int CTRL_MODE_LO = 6;
   localparam int CTRL_ACQ_BIT = 5;
   localparam int CTRL_SPAN_BIT = 4;
   localparam int CTRL_SIGNED_BIT = 3;
   localparam int CTRL_CH_HI = 2;
   localparam int CTRL_CH_LO = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // ====================================
   // power and clock mode codes
   localparam logic [1:0] MODE_NORMAL_EXT = 2'h0;
   localparam logic [1:0] MODE_NORMAL_INT = 2'h1;
   localparam logic [1:0] MODE_STANDBY = 2'h2;
   localparam logic [1:0] MODE_FULL = 2'h3;

   // ====================================
   // result and timing
   localparam int RESULT_W = 12;
   localparam logic [11:0] RESULT_RESET = 12'h000;
   localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;
   localparam logic [3:0] SAR_TOP_BIT = 4'hb;
   localparam logic [3:0] ACQ_CYCLES = 4'h6;
   localparam logic [3:0] CONV_CYCLES = 4'hc;
   localparam longint SYS_CLK_HZ = 200000000;
   localparam longint INT_CLK_HZ = 1560000;
   // integer divide: internal rate lands a touch above the typical figure
   localparam logic [7:0] INT_DIV = 8'(SYS_CLK_HZ / INT_CLK_HZ);
   // clocks after a fresh first trial that ticks are ignored; the synced comparator is valid one clock later still
   localparam logic [1:0] CMP_SETTLE = 2'h2;

   // ====================================
   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACQ_INT = 2'b01,
      ST_ACQ_EXT = 2'b10,
      ST_CONV = 2'b11
   } adcp_state_type;
endpackage : adcp_pkg
`default_nettype wire

// File: logic/adcp_sar.sv
`default_nettype none
module adcp_sar (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   // control
   input wire logic start,
   input wire logic tick,
   input wire logic cmp_above,
   // result
   output logic [11:0] code,
   output logic busy,
   output logic done
);
   logic [3:0] bit_idx_r;
   logic [1:0] settle_r;
   logic [11:0] code_r;
   logic busy_r;
   logic done_r;

   assign code = code_r;
   assign busy = busy_r;
   assign done = done_r;

   // ====================================
   // one decision per conversion-clock tick, msb first
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         code_r <= adcp_pkg::RESULT_RESET;
         bit_idx_r <= 4'h0;
         settle_r <= 2'h0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else if (clk_en) begin
         done_r <= 1'b0;
         if (settle_r != 2'h0) begin
            settle_r <= settle_r - 2'h1;
         end
         if (start) begin // restart wins, so an abort reloads the trial
            code_r <= adcp_pkg::SAR_FIRST_TRIAL;
            bit_idx_r <= adcp_pkg::SAR_TOP_BIT;
            busy_r <= 1'b1;
            // a tick right after start would judge the stale trial
            settle_r <= adcp_pkg::CMP_SETTLE;
         end else if (busy_r && tick && settle_r == 2'h0) begin // [RL13]
            if (!cmp_above) begin
               code_r[bit_idx_r] <= 1'b0;
            end
            if (bit_idx_r == 4'h0) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end else begin
               code_r[bit_idx_r - 4'h1] <= 1'b1;
               bit_idx_r <= bit_idx_r - 4'h1;
            end
         end
      end
   end
endmodule : adcp_sar
`default_nettype wire

// File: logic/adcp_port.sv
// Behaviour
// (RL1) Conversion clock from external clock pin, or internal ~1.56 MHz when selected.
// (RL2) Chip select is active low; strobes count only while it is low.
// (RL3) Internal acquisition: write rising edge latches byte, acquires, then converts.
// (RL4) External acquisition: first write starts acquiring, second ends it and converts.
// (RL5) Read strobe falling edge with chip select low drives result onto bus.
// (RL6) High-byte select picks the 4 top bits, else the 8 low bits.
// (RL7) Pins 3..0 carry bits 11..8 when high byte, else bits 3..0.
// (RL8) Shutdown pin low forces full power-down whatever the control byte says.
// (RL9) Completion flag goes low when a result is ready to read.
// (RL10) Acquisition bit 0: track from write edge, hold after 6 clock cycles.
// (RL11) Acquisition bit 1: track at first edge, hold at second edge with bit 0.
// (RL12) Control bits 3 and 4 pick polarity and full-scale span.
// (RL13) Twelve-bit successive approximation, one decision per bit on held sample.
// (RL14) Byte: mode 7:6, acquisition 5, span 4, polarity 3, channel 2:0.
// (RL15) Mode 00 ext clock, 01 int clock, 10 standby, 11 full; sleep keeps clock.
// (RL16) Unipolar straight binary, bipolar two's complement; high pins 7..4 extend sign.
// (RL17) Conversion lasts 12 clocks; a write during it aborts and restarts acquisition. A sleep-code write aborts to idle instead.
// (RL18) Completion flag returns high on read start or new acquisition.
// (RL19) Data bus not driven while chip select or read strobe is high.
`default_nettype none
module adcp_port (
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   // bus pins
   input wire logic cs_n,
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic high_byte_select,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic done_n,
   // power and conversion clock pins
   input wire logic shutdown_n,
   input wire logic conv_clk_pin,
   // analog front end
   input wire logic cmp_above,
   output logic track,
   output logic [11:0] dac_code,
   output logic [2:0] channel_select,
   output logic range_span_select,
   output logic signed_range_select,
   output logic full_sleep,
   output logic standby_sleep,
   output logic internal_clock_active
);
   // ====================================
   // pin synchronisers, two flops each
   logic [7:0] data_m_r, data_s_r;
   logic [6:0] pin_m_r, pin_s_r;
   logic wr_d_r, rd_d_r, cclk_d_r;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pin_m_r <= 7'h7f;
         pin_s_r <= 7'h7f;
         data_m_r <= 8'h00;
         data_s_r <= 8'h00;
         wr_d_r <= 1'b1;
         rd_d_r <= 1'b1;
         // matches the synced reset level, so no false tick after reset
         cclk_d_r <= 1'b1;
      end else if (clk_en) begin
         pin_m_r <= {cs_n, wr_n, rd_n, high_byte_select, shutdown_n, conv_clk_pin, cmp_above};
         pin_s_r <= pin_m_r;
         data_m_r <= data_in;
         data_s_r <= data_m_r;
         wr_d_r <= pin_s_r[5];
         rd_d_r <= pin_s_r[4];
         cclk_d_r <= pin_s_r[1];
      end
   end

   logic cs_s, wr_s, rd_s, hbs_s, shutdown_n_s, cclk_s, cmp_s;
   assign {cs_s, wr_s, rd_s, hbs_s, shutdown_n_s, cclk_s, cmp_s} = pin_s_r;

   // data goes through the same two stages as the strobe, so the byte
   // seen at the detected edge is the one set up before it
   logic write_ev, read_ev;
   assign write_ev = !cs_s && wr_s && !wr_d_r; // [RL2] [RL3]
   assign read_ev = !cs_s && !rd_s && rd_d_r; // [RL2] [RL5]

   // ====================================
   // control byte
   logic [7:0] ctrl_r;
   logic clk_int_r;
   logic [1:0] wr_mode;
   logic wr_sleep;

   assign wr_mode = data_s_r[adcp_pkg::CTRL_MODE_HI:adcp_pkg::CTRL_MODE_LO]; // [RL14]
   assign wr_sleep = wr_mode[1];

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ctrl_r <= adcp_pkg::CTRL_RESET;
         clk_int_r <= 1'b0;
      end else if (clk_en && write_ev) begin
         ctrl_r <= data_s_r;
         // sleep codes leave the chosen clock source alone
         if (wr_mode == adcp_pkg::MODE_NORMAL_EXT) begin // [RL15]
            clk_int_r <= 1'b0;
         end else if (wr_mode == adcp_pkg::MODE_NORMAL_INT) begin // [RL15]
            clk_int_r <= 1'b1;
         end
      end
   end

   // ====================================
   // power state and mux outputs
   logic full_sleep_r, standby_sleep_r, clk_int_out_r;
   logic [2:0] chan_r;
   logic span_r, signed_r;
   logic [1:0] ctrl_mode;

   assign ctrl_mode = ctrl_r[adcp_pkg::CTRL_MODE_HI:adcp_pkg::CTRL_MODE_LO]; // [RL14]

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         full_sleep_r <= 1'b0;
         standby_sleep_r <= 1'b0;
         clk_int_out_r <= 1'b0;
         chan_r <= 3'h0;
         span_r <= 1'b0;
         signed_r <= 1'b0;
      end else if (clk_en) begin
         full_sleep_r <= !shutdown_n_s || ctrl_mode == adcp_pkg::MODE_FULL; // [RL8] [RL15]
         standby_sleep_r <= shutdown_n_s && ctrl_mode == adcp_pkg::MODE_STANDBY; // [RL15]
         clk_int_out_r <= clk_int_r;
         chan_r <= ctrl_r[adcp_pkg::CTRL_CH_HI:adcp_pkg::CTRL_CH_LO]; // [RL14]
         span_r <= ctrl_r[adcp_pkg::CTRL_SPAN_BIT]; // [RL12]
         signed_r <= ctrl_r[adcp_pkg::CTRL_SIGNED_BIT]; // [RL12]
      end
   end

   // ====================================
   // conversion clock: internal divider or external pin edge
   logic [7:0] div_cnt_r;
   logic tick_r;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         div_cnt_r <= 8'h00;
         tick_r <= 1'b0;
      end else if (clk_en) begin
         if (clk_int_r) begin // [RL1]
            if (div_cnt_r == adcp_pkg::INT_DIV - 8'h01) begin
               div_cnt_r <= 8'h00;
               tick_r <= 1'b1;
            end else begin
               div_cnt_r <= div_cnt_r + 8'h01;
               tick_r <= 1'b0;
            end
         end else begin
            div_cnt_r <= 8'h00;
            tick_r <= cclk_s && !cclk_d_r; // [RL1]
         end
      end
   end

   // ====================================
   // acquisition and conversion sequencer
   adcp_pkg::adcp_state_type state_r;
   logic [3:0] acq_cnt_r;
   logic track_r, sar_start_r, acq_begin_r;
   logic sar_done, sar_busy;
   logic [11:0] sar_code;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_r <= adcp_pkg::ST_IDLE;
         acq_cnt_r <= 4'h0;
         track_r <= 1'b0;
         sar_start_r <= 1'b0;
         acq_begin_r <= 1'b0;
      end else if (clk_en) begin
         sar_start_r <= 1'b0;
         acq_begin_r <= 1'b0;
         if (!shutdown_n_s) begin // [RL8]
            state_r <= adcp_pkg::ST_IDLE;
            track_r <= 1'b0;
         end else if (write_ev && wr_sleep) begin
            state_r <= adcp_pkg::ST_IDLE;
            track_r <= 1'b0;
         end else if (write_ev && data_s_r[adcp_pkg::CTRL_ACQ_BIT]) begin
            state_r <= adcp_pkg::ST_ACQ_EXT; // [RL4] [RL11] [RL17]
            track_r <= 1'b1;
            acq_begin_r <= 1'b1;
         end else if (write_ev && state_r == adcp_pkg::ST_ACQ_EXT) begin
            state_r <= adcp_pkg::ST_CONV; // [RL4] [RL11]
            track_r <= 1'b0;
            sar_start_r <= 1'b1;
         end else if (write_ev) begin
            state_r <= adcp_pkg::ST_ACQ_INT; // [RL3] [RL10] [RL17]
            acq_cnt_r <= 4'h0;
            track_r <= 1'b1;
            acq_begin_r <= 1'b1;
         end else begin
            unique case (state_r)
               adcp_pkg::ST_IDLE: begin
               end
               adcp_pkg::ST_ACQ_INT: begin
                  if (tick_r) begin
                     if (acq_cnt_r == adcp_pkg::ACQ_CYCLES - 4'h1) begin // [RL10]
                        state_r <= adcp_pkg::ST_CONV;
                        track_r <= 1'b0;
                        sar_start_r <= 1'b1;
                     end else begin
                        acq_cnt_r <= acq_cnt_r + 4'h1;
                     end
                  end
               end
               adcp_pkg::ST_ACQ_EXT: begin
               end
               adcp_pkg::ST_CONV: begin
                  if (sar_done) begin
                     state_r <= adcp_pkg::ST_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // a write in the conversion state reaches the sequencer above and restarts
   // acquisition, or idles on a sleep code; the converter then waits for the next start
   adcp_sar u_sar (
      .clk_sys(clk_sys),
      .reset(reset || (clk_en && (!shutdown_n_s || write_ev))),
      .clk_en(clk_en),
      .start(sar_start_r),
      .tick(tick_r),
      .cmp_above(cmp_s),
      .code(sar_code),
      .busy(sar_busy),
      .done(sar_done)
   );

   logic [11:0] dac_code_r;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dac_code_r <= adcp_pkg::RESULT_RESET;
      end else if (clk_en) begin
         dac_code_r <= sar_busy ? sar_code : dac_code_r;
      end
   end

   // ====================================
   // result register and completion flag
   logic [11:0] result_r;
   logic res_signed_r, done_n_r;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         result_r <= adcp_pkg::RESULT_RESET;
         res_signed_r <= 1'b0;
      end else if (clk_en && sar_done && state_r == adcp_pkg::ST_CONV) begin
         // offset binary to two's complement is a flip of the msb
         result_r <= {sar_code[11] ^ signed_r, sar_code[10:0]}; // [RL16]
         res_signed_r <= signed_r;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         done_n_r <= 1'b1;
      end else if (clk_en) begin
         if (sar_done && state_r == adcp_pkg::ST_CONV) begin
            done_n_r <= 1'b0; // [RL9]
         end else if (read_ev || acq_begin_r) begin
            done_n_r <= 1'b1; // [RL18]
         end
      end
   end

   // ====================================
   // read data path
   function automatic logic [7:0] byte_mux(input logic [11:0] res, input logic hi,
                                           input logic sgn);
      logic ext;
      ext = sgn & res[11];
      if (hi) begin
         byte_mux = {{4{ext}}, res[11:8]}; // [RL6] [RL7] [RL16]
      end else begin
         byte_mux = res[7:0]; // [RL6] [RL7]
      end
   endfunction : byte_mux

   logic [7:0] data_out_r;
   logic data_oe_r;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         data_oe_r <= 1'b0;
         data_out_r <= 8'h00;
      end else if (clk_en) begin
         if (cs_s || rd_s) begin
            data_oe_r <= 1'b0; // [RL19]
         end else if (read_ev) begin
            data_oe_r <= 1'b1; // [RL5]
         end
         // follows the byte select for the whole read
         data_out_r <= byte_mux(result_r, hbs_s, res_signed_r);
      end
   end

   // ====================================
   // outputs
   assign data_out = data_out_r;
   assign data_oe = data_oe_r;
   assign done_n = done_n_r;
   assign track = track_r;
   assign dac_code = dac_code_r;
   assign channel_select = chan_r;
   assign range_span_select = span_r;
   assign signed_range_select = signed_r;
   assign full_sleep = full_sleep_r;
   assign standby_sleep = standby_sleep_r;
   assign internal_clock_active = clk_int_out_r;
endmodule : adcp_port
`default_nettype wire

// File: testbench/adcp_host_model.sv
`default_nettype none
module adcp_host_model (
   // clock
   input wire logic clk_sys,
   // analog side
   input wire logic [11:0] sample,
   input wire logic track,
   input wire logic [11:0] dac_code,
   output logic cmp_above,
   // bus
   input wire logic [7:0] cpu_byte,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   output logic [7:0] data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] held_r;
   // ====
   // held sample: frozen once the device leaves tracking
   always_ff @(posedge clk_sys) begin
      if (track) begin
         held_r <= sample;
      end
   end
   assign cmp_above = held_r >= dac_code;
   // host drives the bus only while the device has released it
   assign data_in = data_oe ? data_out : cpu_byte;
endmodule : adcp_host_model
`default_nettype wire

// File: testbench/adcp_port_assertions.sv
`default_nettype none
module adcp_port_chk (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // pins
   input wire logic cs_n,
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic [7:0] data_in,
   input wire logic data_oe,
   input wire logic done_n,
   input wire logic shutdown_n,
   input wire logic track,
   input wire logic full_sleep,
   input wire logic standby_sleep
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   // ====
   // bus cycles
   sequence s_write;
      $rose(wr_n) && !cs_n;
   endsequence
   sequence s_read;
      $fell(rd_n) && !cs_n ##1 (!cs_n && !rd_n) [*5];
   endsequence
   a_write_starts_track: assert property (s_write ##0 (!track && !data_in[7]
      && shutdown_n) |-> ##[3:6] track) else $error("write did not start acquisition");
   a_cs_blocks_write: assert property ($rose(wr_n) && cs_n && !track
      |-> ##1 (!track) [*6]) else $error("write accepted without chip select");
   a_read_drives_bus: assert property (s_read |-> data_oe)
      else $error("bus not driven during read");
   a_cs_release_bus: assert property (cs_n [*5] |-> !data_oe)
      else $error("bus driven without chip select");
   a_rd_release_bus: assert property (rd_n [*5] |-> !data_oe)
      else $error("bus driven without read strobe");
   a_read_clears_done: assert property ($rose(data_oe) |-> done_n)
      else $error("completion flag not cleared by read");
   a_done_after_hold: assert property ($fell(done_n) |-> !track)
      else $error("completion while tracking");
   a_conv_not_short: assert property ($fell(track) |-> done_n [*8])
      else $error("conversion ended too early");
   a_pin_sleep: assert property (!shutdown_n [*4] |-> full_sleep && !track)
      else $error("shutdown pin ignored");
   a_standby_idle: assert property (standby_sleep [*2] |-> !track)
      else $error("tracking in standby");
endmodule : adcp_port_chk
bind adcp_port adcp_port_chk u_chk (.clk_sys(clk_sys), .reset(reset), .cs_n(cs_n),
   .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in), .data_oe(data_oe), .done_n(done_n),
   .shutdown_n(shutdown_n), .track(track), .full_sleep(full_sleep),
   .standby_sleep(standby_sleep));
`default_nettype wire

// File: testbench/adcp_port_bench.sv
`default_nettype none
module adcp_port_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] c; logic [11:0] s;} adcp_row_type;
   logic clk_sys, reset, cs_n, wr_n, rd_n, high_byte_select, shutdown_n, conv_clk_pin;
   logic data_oe, done_n, cmp_above, track, range_span_select, signed_range_select;
   logic full_sleep, standby_sleep, internal_clock_active;
   logic [7:0] data_in, data_out, cpu_byte, rb;
   logic [11:0] dac_code, sample, r;
   logic [2:0] channel_select;
   int mismatches, comparisons, cycles, n, m;
   adcp_row_type rows [4] = '{'{8'h00, 12'hfff}, '{8'h1d, 12'h000}, '{8'h0a, 12'h5a3},
      '{8'h17, 12'h7ff}};
   adcp_port uut (.clk_sys(clk_sys), .reset(reset), .clk_en(1'b1), .cs_n(cs_n),
      .wr_n(wr_n), .rd_n(rd_n), .high_byte_select(high_byte_select), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .done_n(done_n), .shutdown_n(shutdown_n),
      .conv_clk_pin(conv_clk_pin), .cmp_above(cmp_above), .track(track),
      .dac_code(dac_code), .channel_select(channel_select),
      .range_span_select(range_span_select), .signed_range_select(signed_range_select),
      .full_sleep(full_sleep), .standby_sleep(standby_sleep),
      .internal_clock_active(internal_clock_active));
   adcp_host_model host (.clk_sys(clk_sys), .sample(sample), .track(track),
      .dac_code(dac_code), .cmp_above(cmp_above), .cpu_byte(cpu_byte),
      .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
   // ====
   // clocks and hang guard
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // external conversion clock, 8 system cycles a period
   always begin
      repeat (4) @(posedge clk_sys);
      conv_clk_pin <= ~conv_clk_pin;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict;
      end
   end
   // ====
   // tasks
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic cs, input logic [7:0] b);
      @(posedge clk_sys);
      cs_n <= cs;
      cpu_byte <= b;
      repeat (4) @(posedge clk_sys);
      wr_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      wr_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      cs_n <= 1'b1;
      cpu_byte <= ~b;
      repeat (8) @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic h, output logic [7:0] v);
      @(posedge clk_sys);
      cs_n <= 1'b0;
      high_byte_select <= h;
      @(posedge clk_sys);
      rd_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      #1;
      chk(12'({data_oe, done_n}), 12'h3);
      v = data_out;
      @(posedge clk_sys);
      rd_n <= 1'b1;
      cs_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      #1;
      chk(12'(data_oe), 12'h0);
   endtask : rd
   // counts hold cycles up to completion; tracking cycles go to m
   task automatic wait_done(input int lo, input int hi);
      n = 0;
      m = 0;
      while (done_n !== 1'b0 && n < 3000) begin
         @(posedge clk_sys);
         #1;
         if (track === 1'b0) n++;
         else m++;
      end
      chk(12'(n >= lo && n <= hi), 12'h1);
   endtask : wait_done
   task automatic print_verdict;
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict
   // ====
   // sequence
   initial begin
      reset = 1'b1;
      {cs_n, wr_n, rd_n, shutdown_n} = 4'hf;
      {high_byte_select, conv_clk_pin} = 2'h0;
      cpu_byte = 8'h00;
      sample = 12'h000;
      {mismatches, comparisons, cycles} = '0;
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      chk(12'({done_n, data_oe, track, internal_clock_active, full_sleep}), 12'h010);
      wr(1'b1, 8'h07);
      #1;
      chk(12'({track, channel_select}), 12'h0);
      foreach (rows[i]) begin
         sample <= rows[i].s;
         wr(1'b0, rows[i].c);
         wait_done(90, 106);
         chk(12'(m >= 32 && m <= 46), 12'h1);
         r = rows[i].c[3] ? rows[i].s ^ 12'h800 : rows[i].s;
         rd(1'b0, rb);
         chk(12'(rb), 12'(r[7:0]));
         rd(1'b1, rb);
         chk(12'(rb), {4'h0, {4{rows[i].c[3] & r[11]}}, r[11:8]});
         chk(12'({range_span_select, signed_range_select, channel_select}),
             12'(rows[i].c[4:0]));
      end
      sample <= 12'h3c5;
      wr(1'b0, 8'h21);
      repeat (100) @(posedge clk_sys);
      #1;
      chk(12'({track, done_n}), 12'h3);
      wr(1'b0, 8'h02);
      wait_done(90, 106);
      rd(1'b1, rb);
      chk(12'(rb), 12'h003);
      wr(1'b0, 8'h00);
      repeat (60) @(posedge clk_sys);
      sample <= 12'h6e1;
      wr(1'b0, 8'h00);
      wait_done(90, 106);
      wr(1'b0, 8'h00);
      #1;
      chk(12'(done_n), 12'h1);
      wait_done(90, 106);
      rd(1'b0, rb);
      chk(12'(rb), 12'h0e1);
      @(posedge clk_sys);
      shutdown_n <= 1'b0;
      wr(1'b0, 8'h00);
      #1;
      chk(12'({full_sleep, track}), 12'h2);
      @(posedge clk_sys);
      shutdown_n <= 1'b1;
      wr(1'b0, 8'h80);
      #1;
      chk(12'({standby_sleep, full_sleep, internal_clock_active}), 12'h4);
      wr(1'b0, 8'hc0);
      #1;
      chk(12'({standby_sleep, full_sleep, internal_clock_active}), 12'h2);
      sample <= 12'h9a4;
      wr(1'b0, 8'h40);
      wait_done(1530, 1550);
      rd(1'b0, rb);
      chk(12'({internal_clock_active, rb}), 12'h1a4);
      wr(1'b0, 8'hc0);
      #1;
      chk(12'({full_sleep, internal_clock_active, track}), 12'h6);
      print_verdict;
   end
endmodule : adcp_port_bench
`default_nettype wire
